// [hdl/scs_pkg.sv]
package scs_pkg;
    // ----------------------------------------------------------------
    // register map (apb byte addresses, one word per register)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_PROT = 8'h00;
    localparam logic [7:0] OFF_EXT = 8'h04;
    localparam logic [7:0] IDX_CTRL1 = 8'h07;
    localparam logic [7:0] IDX_DETECT = 8'h0C;
    localparam logic [7:0] OFF_CTRL1 = 8'(IDX_CTRL1 * 4);
    localparam logic [7:0] OFF_DETECT = 8'(IDX_DETECT * 4);

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int B_PROT = 0;
    localparam int B_ACS = 0;
    localparam int B_CS1 = 1;
    localparam int B_FBR = 3;
    localparam int B_LSO = 4;
    localparam int B_DRV = 5;
    localparam int B_DIV_LO = 6;
    localparam int B_DIV_HI = 7;
    localparam int B_DEN = 0;
    localparam int B_CS2 = 1;
    localparam int B_FLAG = 2;
    localparam int B_MON = 3;
    localparam int B_ACT = 7;
    localparam int B_MCS = 0;
    localparam int B_D8 = 1;
    localparam int B_SUB = 2;
    localparam int B_LOCK = 3;
    localparam int B_WDP = 4;

    // ----------------------------------------------------------------
    // reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL1_RST = 8'h20;
    localparam logic [7:0] DETECT_RST = 8'h02;
    localparam logic [7:0] EXT_RST = 8'h02;
    localparam logic [7:0] CTRL1_WMASK = 8'hFB;
    localparam logic [7:0] EXT_WMASK = 8'h1F;
    localparam int SYNC_DEPTH = 3;

    // effective main clock division, as log2 of the ratio
    localparam logic [2:0] DIV_LOG_1 = 3'h0;
    localparam logic [2:0] DIV_LOG_2 = 3'h1;
    localparam logic [2:0] DIV_LOG_4 = 3'h2;
    localparam logic [2:0] DIV_LOG_8 = 3'h3;
    localparam logic [2:0] DIV_LOG_16 = 3'h4;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_MAIN = 2'h0,
        SRC_PLL = 2'h1,
        SRC_OCO = 2'h2,
        SRC_SUB = 2'h3
    } scs_src_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACC = 2'b10
    } scs_apb_st_t;

    typedef struct packed {
        scs_src_t cpu_src;
        scs_src_t f1_src;
    } scs_clk_sel_t;

    typedef struct packed {
        logic stop_mode;
        logic feedback_off;
        logic low_speed_off;
        logic drive_high;
    } scs_osc_ctl_t;
endpackage : scs_pkg

// [hdl/scs_clock_ctrl.sv]
`timescale 1ns/1ns
// What this block does
// [R1] all-clock-stop write of 1 enters stop mode
// [R2] software avoids stop with PLL or detector
// [R3] stop request ignored on lock, protect, nmi
// [R4] clock-select-1 picks main or PLL
// [R5] sub select limits clock-select-1 to f1
// [R6] lock freezes clock-select-1
// [R7] feedback resistor off bit, forced in stop
// [R8] low-speed stop forced 0 on oscillator select
// [R9] watchdog protect forces low-speed stop 0
// [R10] drive high set on stop, or on main-stop while select-2 is clear
// [R11] two-bit main divider unless divide-by-eight
// [R12] writes need clock-register protect bit set
// [R13] detector enable frozen by lock
// [R14] software clears detector before stop mode
// [R15] clock-select-2 picks on-chip oscillator
// [R16] software keeps select-2 while main stopped
// [R17] detected stop forces clock-select-2 to 1 under interrupt action while main feeds the cpu
// [R18] detect flag shows stop or restart seen
// [R19] monitor flag reads oscillator state, read-only
// [R20] action bit picks reset or interrupt
// [R21] detector reset keeps enable, select-2, action
// [R22] reserved bits read zero
// [R23] flag cleared by writing 0 only
// [R24] interrupt only on flag rising edge
module scs_clock_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and neighbouring logic
    input wire logic nmi_n,
    input wire logic main_osc_stopped,
    input wire logic stop_wake,
    // clock steering
    output scs_pkg::scs_clk_sel_t clk_sel,
    output scs_pkg::scs_osc_ctl_t osc_ctl,
    output logic [2:0] main_div_log,
    // detector events
    output logic osc_stop_irq,
    output logic osc_stop_reset_req
);
    import scs_pkg::*;

    // bits that survive the detector's own reset
    localparam logic [7:0] DET_KEEP = (8'h01 << B_DEN) | (8'h01 << B_CS2) |
                                      (8'h01 << B_ACT);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    scs_apb_st_t st_reg;
    logic [7:0] prot_reg;
    logic [7:0] ext_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] det_reg;
    logic [SYNC_DEPTH-1:0] nmi_sync_reg;
    logic [SYNC_DEPTH-1:0] osc_sync_reg;
    logic nmi_n_reg;
    logic osc_stopped_reg;
    logic det_rst_reg;
    logic wr_en;
    logic [7:0] wdat;
    logic osc_change;
    logic stop_seen;
    logic lock;
    logic wdp;
    logic main_feeds_cpu;

    function automatic scs_src_t src_of(input logic cs1, input logic cs2);
        if (cs2) begin
            return SRC_OCO;
        end
        return cs1 ? SRC_PLL : SRC_MAIN;
    endfunction : src_of

    // write one bit unless locked
    function automatic logic keep_or_write(input logic cur, input logic nv,
                                           input logic locked);
        return locked ? cur : nv;
    endfunction : keep_or_write

    // ----------------------------------------------------------------
    // apb slave: one wait-free access cycle after setup
    // ----------------------------------------------------------------
    assign wr_en = psel && penable && pwrite && pready;
    assign wdat = pwdata[7:0];
    assign lock = ext_reg[B_LOCK];
    assign wdp = ext_reg[B_WDP];

    // pready rises in the access phase, read data captured in setup
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && !penable) begin
                        st_reg <= ST_ACC;
                        pready <= 1'b1;
                        prdata <= 32'h0000_0000;
                        case (paddr)
                            OFF_PROT: prdata[7:0] <= prot_reg;
                            OFF_EXT: prdata[7:0] <= ext_reg;
                            OFF_CTRL1: prdata[7:0] <= ctrl1_reg;
                            // unimplemented bits 6:4 read as zero
                            OFF_DETECT: prdata[7:0] <= {det_reg[7:4],
                                osc_stopped_reg, det_reg[2:0]}; // see [R19]
                            default: pslverr <= 1'b1;
                        endcase
                    end
                end
                ST_ACC: begin
                    st_reg <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    st_reg <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // input synchronisers: change accepted once stages two and three agree
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_sync_reg <= '1;
            osc_sync_reg <= '0;
            nmi_n_reg <= 1'b1;
            osc_stopped_reg <= 1'b0;
        end else begin
            nmi_sync_reg <= {nmi_sync_reg[SYNC_DEPTH-2:0], nmi_n};
            osc_sync_reg <= {osc_sync_reg[SYNC_DEPTH-2:0], main_osc_stopped};
            if (nmi_sync_reg[1] == nmi_sync_reg[2]) begin
                nmi_n_reg <= nmi_sync_reg[2];
            end
            if (osc_sync_reg[1] == osc_sync_reg[2]) begin
                osc_stopped_reg <= osc_sync_reg[2];
            end
        end
    end

    // stop and restart both count while the detector is enabled
    assign osc_change = (osc_sync_reg[1] == osc_sync_reg[2]) &&
                        (osc_sync_reg[2] != osc_stopped_reg) &&
                        det_reg[B_DEN];
    assign stop_seen = osc_change && osc_sync_reg[2];
    assign main_feeds_cpu = !ext_reg[B_SUB] && !det_reg[B_CS2] &&
                            !ctrl1_reg[B_CS1];

    // ----------------------------------------------------------------
    // protect and neighbour control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prot_reg <= 8'h00;
        end else if (det_rst_reg) begin
            prot_reg <= 8'h00;
        end else if (wr_en && paddr == OFF_PROT) begin
            prot_reg <= {7'h00, wdat[B_PROT]};
        end
    end

    // neighbour bits live here so the block can be steered standalone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_reg <= EXT_RST;
        end else if (det_rst_reg) begin
            ext_reg <= EXT_RST;
        end else begin
            if (wr_en && paddr == OFF_EXT) begin
                ext_reg <= wdat & EXT_WMASK;
            end
            // stop entry forces divide-by-eight, held while stopped
            if (ctrl1_reg[B_ACS]) begin
                ext_reg[B_D8] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // first clock control register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_reg <= CTRL1_RST;
        end else if (det_rst_reg) begin
            ctrl1_reg <= CTRL1_RST;
        end else begin
            if (wr_en && paddr == OFF_CTRL1 && prot_reg[B_PROT]) begin // see [R12]
                ctrl1_reg <= wdat & CTRL1_WMASK; // see [R22]
                ctrl1_reg[B_ACS] <= keep_or_write(ctrl1_reg[B_ACS],
                    wdat[B_ACS], lock || wdp || !nmi_n_reg); // see [R3]
                ctrl1_reg[B_CS1] <= keep_or_write(ctrl1_reg[B_CS1],
                    wdat[B_CS1], lock); // see [R6]
            end
            // wake from outside leaves stop mode
            if (stop_wake && ctrl1_reg[B_ACS]) begin
                ctrl1_reg[B_ACS] <= 1'b0;
            end
            // low-speed oscillator may not stop here
            if (det_reg[B_CS2] || wdp) begin
                ctrl1_reg[B_LSO] <= 1'b0; // see [R8] see [R9]
            end
            // high drive so the crystal restarts reliably
            if (ctrl1_reg[B_ACS] ||
                (!det_reg[B_CS2] && ext_reg[B_MCS])) begin
                ctrl1_reg[B_DRV] <= 1'b1; // see [R10]
            end
        end
    end

    // ----------------------------------------------------------------
    // detection register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            det_reg <= DETECT_RST;
        end else if (det_rst_reg) begin
            // detector reset keeps enable, select-2 and action
            det_reg <= (DETECT_RST & ~DET_KEEP) |
                       (det_reg & DET_KEEP); // see [R21]
        end else begin
            if (wr_en && paddr == OFF_DETECT && prot_reg[B_PROT]) begin // see [R12]
                det_reg[B_DEN] <= keep_or_write(det_reg[B_DEN],
                    wdat[B_DEN], lock); // see [R13]
                det_reg[B_CS2] <= wdat[B_CS2]; // see [R15]
                det_reg[B_ACT] <= wdat[B_ACT]; // see [R20]
                if (!wdat[B_FLAG]) begin
                    det_reg[B_FLAG] <= 1'b0; // see [R23]
                end
            end
            // hardware set wins over a software clear in the same cycle
            if (osc_change) begin
                det_reg[B_FLAG] <= 1'b1; // see [R18]
            end
            if (stop_seen && det_reg[B_ACT] && main_feeds_cpu) begin
                det_reg[B_CS2] <= 1'b1; // see [R17]
            end
        end
    end

    // ----------------------------------------------------------------
    // detector action: interrupt on flag rise, or a local reset
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_stop_irq <= 1'b0;
            osc_stop_reset_req <= 1'b0;
            det_rst_reg <= 1'b0;
        end else begin
            osc_stop_irq <= osc_change && det_reg[B_ACT] &&
                            !det_reg[B_FLAG]; // see [R24]
            // restart alone never resets the chip
            osc_stop_reset_req <= stop_seen && !det_reg[B_ACT]; // see [R20]
            det_rst_reg <= stop_seen && !det_reg[B_ACT];
        end
    end

    // ----------------------------------------------------------------
    // registered clock steering outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_sel <= '{cpu_src: SRC_OCO, f1_src: SRC_OCO};
            osc_ctl <= '0;
            main_div_log <= DIV_LOG_8;
        end else begin
            clk_sel.f1_src <= src_of(ctrl1_reg[B_CS1], det_reg[B_CS2]); // see [R4]
            clk_sel.cpu_src <= ext_reg[B_SUB] ? SRC_SUB :
                src_of(ctrl1_reg[B_CS1], det_reg[B_CS2]); // see [R5] see [R15]
            osc_ctl.stop_mode <= ctrl1_reg[B_ACS]; // see [R1]
            osc_ctl.feedback_off <= ctrl1_reg[B_FBR] ||
                                    ctrl1_reg[B_ACS]; // see [R7]
            osc_ctl.low_speed_off <= ctrl1_reg[B_LSO] && !det_reg[B_CS2] &&
                                     !wdp; // see [R8] see [R9]
            osc_ctl.drive_high <= ctrl1_reg[B_DRV];
            if (ext_reg[B_D8]) begin
                main_div_log <= DIV_LOG_8;
            end else begin
                case (ctrl1_reg[B_DIV_HI:B_DIV_LO]) // see [R11]
                    2'h0: main_div_log <= DIV_LOG_1;
                    2'h1: main_div_log <= DIV_LOG_2;
                    2'h2: main_div_log <= DIV_LOG_4;
                    default: main_div_log <= DIV_LOG_16;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_stop_req;
        wr_en && paddr == OFF_CTRL1 && prot_reg[B_PROT] && wdat[B_ACS];
    endsequence

    sequence s_stop_blocked;
        s_stop_req ##0 (lock || wdp || !nmi_n_reg) && !ctrl1_reg[B_ACS];
    endsequence

    property p_stop_enter;
        @(posedge clk) disable iff (!arst_n)
        s_stop_req ##0 !(lock || wdp || !nmi_n_reg) && !stop_wake
        |=> ##1 osc_ctl.stop_mode && osc_ctl.feedback_off;
    endproperty
    a_stop_enter: assert property (p_stop_enter) // see [R1]
        else $error("stop request did not reach stop mode");

    property p_stop_blocked;
        @(posedge clk) disable iff (!arst_n)
        s_stop_blocked |=> !ctrl1_reg[B_ACS];
    endproperty
    a_stop_blocked: assert property (p_stop_blocked) // see [R3]
        else $error("blocked stop request changed the bit");

    property p_unprotected;
        @(posedge clk) disable iff (!arst_n)
        wr_en && paddr == OFF_CTRL1 && !prot_reg[B_PROT] && !stop_wake &&
        !det_rst_reg |=> ctrl1_reg[B_CS1] == $past(ctrl1_reg[B_CS1]);
    endproperty
    a_unprotected: assert property (p_unprotected) // see [R12]
        else $error("write without protect altered register");

    property p_cs1_lock;
        @(posedge clk) disable iff (!arst_n)
        lock && !det_rst_reg |=> $stable(ctrl1_reg[B_CS1]);
    endproperty
    a_cs1_lock: assert property (p_cs1_lock) // see [R6]
        else $error("locked select-1 changed");

    property p_lso_forced;
        @(posedge clk) disable iff (!arst_n)
        (det_reg[B_CS2] || wdp) |=> ##1 !osc_ctl.low_speed_off;
    endproperty
    a_lso_forced: assert property (p_lso_forced) // see [R8]
        else $error("low-speed oscillator stopped while forced on");

    property p_drive_high;
        @(posedge clk) disable iff (!arst_n)
        ctrl1_reg[B_ACS] && !det_rst_reg |=> ##1 osc_ctl.drive_high;
    endproperty
    a_drive_high: assert property (p_drive_high) // see [R10]
        else $error("drive not raised in stop mode");

    property p_irq_edge;
        @(posedge clk) disable iff (!arst_n)
        osc_stop_irq |-> $rose(det_reg[B_FLAG]) && det_reg[B_ACT];
    endproperty
    a_irq_edge: assert property (p_irq_edge) // see [R24]
        else $error("interrupt without flag rising");

    property p_flag_set;
        @(posedge clk) disable iff (!arst_n)
        osc_change && !det_rst_reg |=> det_reg[B_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set) // see [R18]
        else $error("detection did not set flag");

    property p_keep_bits;
        @(posedge clk) disable iff (!arst_n)
        det_rst_reg |=> det_reg[B_DEN] == $past(det_reg[B_DEN]) &&
                        det_reg[B_ACT] == $past(det_reg[B_ACT]) &&
                        det_reg[B_CS2] == $past(det_reg[B_CS2]);
    endproperty
    a_keep_bits: assert property (p_keep_bits) // see [R21]
        else $error("detector reset lost kept bits");

    property p_div8;
        @(posedge clk) disable iff (!arst_n)
        ext_reg[B_D8] |=> main_div_log == DIV_LOG_8;
    endproperty
    a_div8: assert property (p_div8) // see [R11]
        else $error("divide-by-eight not applied");
endmodule : scs_clock_ctrl

// [test/test_system_clock_select_and_osc_stop_detect.sv]
`timescale 1ns/1ns
module test_system_clock_select_and_osc_stop_detect;
    import scs_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk, arst_n, psel, penable, pwrite, last_err;
    logic nmi_n, main_osc_stopped, stop_wake;
    logic pready, pslverr, osc_stop_irq, osc_stop_reset_req;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] d;
    logic [2:0] main_div_log;
    scs_clk_sel_t clk_sel;
    scs_osc_ctl_t osc_ctl;
    int num_errors, tests_run, irq_cnt, n0;

    scs_clock_ctrl u_scs_clock_ctrl (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nmi_n(nmi_n), .main_osc_stopped(main_osc_stopped),
        .stop_wake(stop_wake), .clk_sel(clk_sel), .osc_ctl(osc_ctl),
        .main_div_log(main_div_log), .osc_stop_irq(osc_stop_irq),
        .osc_stop_reset_req(osc_stop_reset_req)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // irq pulses last one cycle, so count them at every edge
    always @(posedge clk) begin
        if (osc_stop_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task report_and_stop;
        $display("tests_run %0d num_errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task done(input string s);
        $display("test %s finished", s);
    endtask : done

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // request held until pready is sampled high, then released
    task apb(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), v};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, v);
    endtask : wr

    task rd(input logic [7:0] a);
        apb(1'b0, a, 8'h00);
    endtask : rd

    // bounded wait for an irq (0) or reset request (1) pulse
    task wait_evt(input bit which);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((which ? osc_stop_reset_req : osc_stop_irq) !== 1'b1
                   && n < 40);
        if ((which ? osc_stop_reset_req : osc_stop_irq) !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_evt

    function automatic logic [3:0] exp_sel(logic cs1, logic cs2,
                                           logic sub);
        logic [1:0] f;
        f = cs2 ? SRC_OCO : (cs1 ? SRC_PLL : SRC_MAIN);
        return {(sub ? SRC_SUB : f), f};
    endfunction : exp_sel

    function automatic logic [2:0] exp_div(logic [1:0] v, logic d8);
        return d8 ? DIV_LOG_8 : (v == 2'h3 ? DIV_LOG_16 : 3'(v));
    endfunction : exp_div

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; nmi_n = 1'b1; main_osc_stopped = 1'b0;
        stop_wake = 1'b0; arst_n = 1'b0; irq_cnt = 0;
        num_errors = 0; tests_run = 0;
        void'($urandom(32'hD43F));
        tick(10);
        arst_n <= 1'b1;
        tick(2);
        rd(OFF_CTRL1); chk(rdat, 32'h20);
        rd(OFF_DETECT); chk(rdat, 32'h02);
        chk(32'(clk_sel), 32'(exp_sel(0, 1, 0)));
        wr(OFF_CTRL1, 8'h80); rd(OFF_CTRL1); chk(rdat, 32'h20);
        rd(8'hF0); chk(last_err, 1); chk(rdat, 0);
        done("reset_protect");
        // random main clock settings with select-2 cleared
        wr(OFF_PROT, 8'h01);
        wr(OFF_EXT, 8'h00); wr(OFF_DETECT, 8'h00);
        repeat (12) begin
            d = 8'($urandom) & 8'hFE;
            wr(OFF_CTRL1, d); rd(OFF_CTRL1);
            chk(rdat, 32'(d & 8'hFA));
            tick(2);
            chk(main_div_log, exp_div(d[7:6], 1'b0));
            chk(32'(clk_sel), 32'(exp_sel(d[1], 0, 0)));
            chk(osc_ctl.feedback_off, d[3]);
            chk(osc_ctl.low_speed_off, d[4]);
        end
        wr(OFF_CTRL1, 8'hC2); wr(OFF_EXT, 8'h06); tick(2);
        chk(main_div_log, DIV_LOG_8);
        chk(32'(clk_sel), 32'(exp_sel(1, 0, 1)));
        wr(OFF_DETECT, 8'h02); tick(2);
        chk(32'(clk_sel), 32'(exp_sel(1, 1, 1)));
        done("select_divide");
        wr(OFF_CTRL1, 8'h10); rd(OFF_CTRL1); chk(rdat, 0);
        wr(OFF_DETECT, 8'h00); wr(OFF_EXT, 8'h10);
        wr(OFF_CTRL1, 8'h10); rd(OFF_CTRL1); chk(rdat, 0);
        wr(OFF_EXT, 8'h00);
        wr(OFF_CTRL1, 8'h10); rd(OFF_CTRL1); chk(rdat, 32'h10);
        wr(OFF_EXT, 8'h01); wr(OFF_CTRL1, 8'h00); tick(2);
        chk(osc_ctl.drive_high, 1);
        rd(OFF_CTRL1); chk(rdat, 32'h20);
        done("forcing");
        wr(OFF_EXT, 8'h08); wr(OFF_CTRL1, 8'h02);
        rd(OFF_CTRL1); chk(rdat[1], 0);
        wr(OFF_DETECT, 8'h01); rd(OFF_DETECT); chk(rdat, 0);
        // stop refused under lock, watchdog protect, nmi low
        for (int k = 0; k < 3; k++) begin
            wr(OFF_EXT, k == 0 ? 8'h08 : (k == 1 ? 8'h10 : 8'h00));
            nmi_n <= (k != 2);
            tick(4);
            wr(OFF_CTRL1, 8'h01); tick(2);
            chk(osc_ctl.stop_mode, 0);
        end
        nmi_n <= 1'b1;
        wr(OFF_EXT, 8'h00); tick(4);
        // pll deselected and detector off before asking for stop
        wr(OFF_CTRL1, 8'h01);
        // drive high lags the forced register bit by one more edge
        tick(3);
        chk(32'(osc_ctl), 32'hD);
        @(posedge clk) stop_wake <= 1'b1;
        @(posedge clk) stop_wake <= 1'b0;
        tick(2);
        chk(osc_ctl.stop_mode, 0);
        done("lock_stop");
        // detection with interrupt action, main clock feeding the cpu
        wr(OFF_EXT, 8'h00); wr(OFF_CTRL1, 8'h00); wr(OFF_DETECT, 8'h81);
        n0 = irq_cnt;
        main_osc_stopped <= 1'b1;
        wait_evt(1'b0);
        tick(3);
        chk(32'(clk_sel), 32'(exp_sel(0, 1, 0)));
        rd(OFF_DETECT); chk(rdat, 32'h8F);
        main_osc_stopped <= 1'b0;
        tick(10);
        chk(irq_cnt - n0, 1);
        rd(OFF_DETECT); chk(rdat, 32'h87);
        wr(OFF_DETECT, 8'h8B); rd(OFF_DETECT); chk(rdat, 32'h83);
        wr(OFF_DETECT, 8'h87); rd(OFF_DETECT); chk(rdat, 32'h83);
        done("detect_irq");
        // detection with reset action; main clock runs again here
        wr(OFF_DETECT, 8'h01);
        main_osc_stopped <= 1'b1;
        wait_evt(1'b1);
        tick(4);
        rd(OFF_DETECT); chk(rdat, 32'h09);
        rd(OFF_CTRL1); chk(rdat, 32'h20);
        chk(irq_cnt - n0, 1);
        main_osc_stopped <= 1'b0;
        done("detect_reset");
        report_and_stop();
    end
endmodule : test_system_clock_select_and_osc_stop_detect
